// ===== rtl/ise_pkg.sv
// constants of the two-wire slave receive engine
package ise_pkg;
  localparam logic [7:0] OFS_ADDR_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL      = 8'h04;
  localparam logic [7:0] OFS_STAT      = 8'h08;
  localparam logic [7:0] OFS_MASK      = 8'h0C;
  localparam logic [7:0] OFS_DATA      = 8'h10;
  localparam logic [7:0] OFS_DIV       = 8'h14;
  // control register bits
  localparam int CT_BUS_EN   = 0;
  localparam int CT_IRQ_EN   = 1;
  localparam int CT_MASTER   = 2;
  localparam int CT_TRANSMIT = 3;
  localparam int CT_ACKCTL   = 4;
  localparam int CT_RANGE    = 5;
  localparam int CT_ACKMODE  = 6;
  localparam int CT_BUSY     = 7;
  // bus mode register fields
  localparam int MD_ORDER = 7;
  localparam int MD_WAIT  = 6;
  localparam int MD_CKS   = 3;
  // status bits, sticky, write one to clear
  localparam int ST_DONE  = 0;
  localparam int ST_START = 1;
  localparam int ST_STOP  = 2;
  localparam int ST_W     = 3;
  localparam logic [ST_W-1:0] MASK_RST = 3'h1;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam logic [3:0] BITS_BYTE    = 4'h8;
  localparam logic [3:0] BITS_LAST_TX = 4'h7;
  // base divisor of the transfer clock, in sys_clk cycles; value is arbitrary
  localparam logic [11:0] DIV_BASE = 12'h01C;
  typedef enum logic [2:0] {
    ISE_IDLE, ISE_RECV, ISE_ACK, ISE_HOLD, ISE_TX, ISE_TXACK, ISE_SKIP
  } ise_state_e;
endpackage

// ===== rtl/ise_slave_engine.sv
// two-wire bus slave receive engine with ahb-lite register port
`timescale 1ns/100ps
// Function
// - the transfer clock divisor follows the three clock select bits and the range bit.
// - the interrupt is raised while the transfer done flag is set and both its mask bit and the interrupt enable bit are one.
// - master select and transmit select both zero put the engine in slave reception.
// - with acknowledge control and acknowledge mode both zero every received data byte is acknowledged.
// - a start condition sets the bus busy flag.
// - the first byte is compared with the own address and a match acknowledges and sets done.
// - the clock line is held low from the ninth falling clock edge until the data is read in reception, or until it is written in transmission.
// - reading the data register releases the clock line for the next byte in reception; in transmission writing it does.
// - a stop condition clears the bus busy flag.
// - after its address the engine receives when the read/write bit is zero, and transmits data when it is one.
// - with bus enable set the shared offset reaches the mode register, else the address one.
// - a read/write bit of one in the address byte sets transmit select.
module ise_slave_engine
  import ise_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);
  import ise_pkg::*;

  typedef struct packed {
    logic            hready;
    logic [31:0]     hrdata;
    logic            ph_wr;
    logic            ph_rd;
    logic [7:0]      ph_addr;
    logic [7:0]      own_addr;
    logic [7:0]      mode;
    logic [7:0]      ctrl;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic            irq;
    logic            scl_s1;
    logic            scl_s2;
    logic            scl_p;
    logic            sda_s1;
    logic            sda_s2;
    logic            sda_p;
    ise_state_e      st;
    logic            addr_phase;
    logic [3:0]      bitcnt;
    logic [7:0]      shift;
    logic [7:0]      data;
    logic [7:0]      txd;
    logic            scl_oe;
    logic            sda_oe;
  } ise_state_s;

  ise_state_s s_q;
  ise_state_s s_d;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // edges are read from the second and third stage only, never the first
  assign scl_rise  = s_q.scl_s2 & ~s_q.scl_p;
  assign scl_fall  = ~s_q.scl_s2 & s_q.scl_p;
  assign start_det = s_q.scl_s2 & s_q.scl_p & ~s_q.sda_s2 & s_q.sda_p;
  assign stop_det  = s_q.scl_s2 & s_q.scl_p & s_q.sda_s2 & ~s_q.sda_p;

  function automatic logic [11:0] clk_div(input logic [2:0] cks, input logic range);
    logic [11:0] d;
    d = DIV_BASE << cks;
    if (range) begin
      d = d << 1;
    end
    return d;
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b,
                                          input logic lsb_first);
    if (lsb_first) begin
      return {b, sr[7:1]};
    end
    return {sr[6:0], b};
  endfunction

  always_comb begin
    logic [31:0]     rdv;
    logic [ST_W-1:0] clr;
    logic [ST_W-1:0] set;
    logic            rd_data;
    logic            wr_data;
    logic            engine_on;
    logic            match;
    rdv       = 32'h0000_0000;
    clr       = '0;
    set       = '0;
    rd_data   = 1'b0;
    wr_data   = 1'b0;
    match     = 1'b0;
    engine_on = s_q.ctrl[CT_BUS_EN] & ~s_q.ctrl[CT_MASTER];
    s_d       = s_q;
    s_d.scl_s1 = scl_i;
    s_d.scl_s2 = s_q.scl_s1;
    s_d.scl_p  = s_q.scl_s2;
    s_d.sda_s1 = sda_i;
    s_d.sda_s2 = s_q.sda_s1;
    s_d.sda_p  = s_q.sda_s2;

    // data phase of a write: zero wait states
    s_d.ph_wr = 1'b0;
    if (s_q.ph_wr) begin
      case (s_q.ph_addr)
        OFS_ADDR_MODE: begin
          if (s_q.ctrl[CT_BUS_EN]) begin
            s_d.mode = hwdata[7:0] & 8'hF8;
          end else begin
            s_d.own_addr = hwdata[7:0];
          end
        end
        OFS_CTRL: begin
          s_d.ctrl = {s_q.ctrl[CT_BUSY], hwdata[6:0]};
        end
        OFS_STAT: begin
          clr = hwdata[ST_W-1:0];
        end
        OFS_MASK: begin
          s_d.mask = hwdata[ST_W-1:0];
        end
        OFS_DATA: begin
          s_d.txd = hwdata[7:0];
          wr_data = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // read takes one wait state so a preceding write is always visible
    if (s_q.ph_rd) begin
      case (s_q.ph_addr)
        OFS_ADDR_MODE: begin
          rdv[7:0] = s_q.ctrl[CT_BUS_EN] ? s_q.mode : s_q.own_addr;
        end
        OFS_CTRL: begin
          rdv[7:0] = s_q.ctrl;
        end
        OFS_STAT: begin
          rdv[ST_W-1:0] = s_q.stat;
        end
        OFS_MASK: begin
          rdv[ST_W-1:0] = s_q.mask;
        end
        OFS_DATA: begin
          rdv[7:0] = s_q.data;
          rd_data  = 1'b1;
        end
        OFS_DIV: begin
          rdv[11:0] = clk_div(s_q.mode[MD_CKS +: 3], s_q.ctrl[CT_RANGE]);
        end
        default: begin
          rdv = 32'h0000_0000;
        end
      endcase
      s_d.hrdata = rdv;
      s_d.hready = 1'b1;
      s_d.ph_rd  = 1'b0;
    end

    // address phase
    if (hsel && hready && htrans[1]) begin
      s_d.ph_addr = haddr[7:0];
      if (hwrite) begin
        s_d.ph_wr = 1'b1;
      end else begin
        s_d.ph_rd  = 1'b1;
        s_d.hready = 1'b0;
      end
    end

    if (!s_q.ctrl[CT_BUS_EN]) begin
      s_d.ctrl[CT_BUSY] = 1'b0;
    end else if (start_det) begin
      s_d.ctrl[CT_BUSY] = 1'b1;
      set[ST_START]     = 1'b1;
    end else if (stop_det) begin
      s_d.ctrl[CT_BUSY] = 1'b0;
      set[ST_STOP]      = 1'b1;
    end

    if (!engine_on) begin
      s_d.st     = ISE_IDLE;
      s_d.scl_oe = 1'b0;
      s_d.sda_oe = 1'b0;
    end else if (start_det) begin
      // a repeated start also lands here and restarts address reception
      s_d.st         = ISE_RECV;
      s_d.addr_phase = 1'b1;
      s_d.bitcnt     = 4'h0;
      s_d.scl_oe     = 1'b0;
      s_d.sda_oe     = 1'b0;
    end else if (stop_det) begin
      s_d.st     = ISE_IDLE;
      s_d.scl_oe = 1'b0;
      s_d.sda_oe = 1'b0;
    end else begin
      case (s_q.st)
        ISE_RECV: begin
          if (scl_rise) begin
            s_d.shift  = shift_in(s_q.shift, s_q.sda_s2, s_q.mode[MD_ORDER]);
            s_d.bitcnt = s_q.bitcnt + 4'h1;
          end else if (scl_fall && s_q.bitcnt == BITS_BYTE) begin
            if (s_q.addr_phase) begin
              match = (s_q.shift[7:1] == s_q.own_addr[7:1]) && !s_q.own_addr[0];
              if (match) begin
                s_d.data   = s_q.shift;
                s_d.sda_oe = 1'b1;
                s_d.st     = ISE_ACK;
                s_d.ctrl[CT_TRANSMIT] = s_q.shift[0];
              end else begin
                s_d.st = ISE_SKIP;
              end
            end else begin
              s_d.data   = s_q.shift;
              s_d.sda_oe = ~s_q.ctrl[CT_ACKCTL] & ~s_q.ctrl[CT_ACKMODE];
              s_d.st     = ISE_ACK;
            end
          end
        end
        ISE_ACK: begin
          if (scl_rise) begin
            set[ST_DONE] = 1'b1;
          end else if (scl_fall) begin
            s_d.sda_oe     = 1'b0;
            s_d.scl_oe     = 1'b1;
            s_d.st         = ISE_HOLD;
            s_d.addr_phase = 1'b0;
            s_d.bitcnt     = 4'h0;
          end
        end
        ISE_HOLD: begin
          // receive waits on a data read, transmit on a data write
          if (s_d.ctrl[CT_TRANSMIT] && wr_data) begin
            s_d.shift  = hwdata[7:0];
            s_d.sda_oe = ~hwdata[7];
            s_d.st     = ISE_TX;
          end else if (!s_d.ctrl[CT_TRANSMIT] && rd_data) begin
            s_d.scl_oe = 1'b0;
            s_d.st     = ISE_RECV;
          end
        end
        ISE_TX: begin
          // clock freed a cycle after the first bit so data leads the rising clock
          s_d.scl_oe = 1'b0;
          if (scl_fall) begin
            s_d.shift  = {s_q.shift[6:0], 1'b0};
            s_d.bitcnt = s_q.bitcnt + 4'h1;
            if (s_q.bitcnt == BITS_LAST_TX) begin
              s_d.sda_oe = 1'b0;
              s_d.st     = ISE_TXACK;
            end else begin
              s_d.sda_oe = ~s_q.shift[6];
            end
          end
        end
        ISE_TXACK: begin
          // master acknowledge lands in acknowledge control
          if (scl_rise) begin
            s_d.ctrl[CT_ACKCTL] = s_q.sda_s2;
            set[ST_DONE]        = 1'b1;
          end else if (scl_fall) begin
            s_d.scl_oe = 1'b1;
            s_d.bitcnt = 4'h0;
            s_d.st     = ISE_HOLD;
          end
        end
        ISE_SKIP, ISE_IDLE: begin
          s_d.sda_oe = 1'b0;
          s_d.scl_oe = 1'b0;
        end
        default: begin
          s_d.st = ISE_IDLE;
        end
      endcase
    end

    // a flag set by hardware wins over the clear in the same cycle
    s_d.stat = (s_q.stat & ~clr) | set;
    s_d.irq  = |(s_q.stat & s_q.mask & {{(ST_W-1){1'b1}}, s_q.ctrl[CT_IRQ_EN]});
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q            <= '0;
      s_q.hready     <= 1'b1;
      s_q.own_addr   <= OWN_ADDR_RST;
      s_q.mode       <= MODE_RST;
      s_q.mask       <= MASK_RST;
      s_q.st         <= ISE_IDLE;
      s_q.scl_s1     <= 1'b1;
      s_q.scl_s2     <= 1'b1;
      s_q.scl_p      <= 1'b1;
      s_q.sda_s1     <= 1'b1;
      s_q.sda_s2     <= 1'b1;
      s_q.sda_p      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // open-drain pins only ever pull low
  assign hreadyout = s_q.hready;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.hrdata;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = s_q.scl_oe;
  assign sda_oe    = s_q.sda_oe;
  assign irq       = s_q.irq;
endmodule

// ===== tb/ise_slave_engine_asserts.sv
// port assertions of the two-wire slave engine
`timescale 1ns/100ps
module ise_slave_engine_asserts
  import ise_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        scl_i,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        irq
);
  logic acc;
  logic dp_q;
  logic rd_q;
  assign acc = hsel && hready && htrans[1];
  always_ff @(posedge sys_clk) begin
    dp_q <= !rst && acc && haddr[7:0] == OFS_DATA;
    rd_q <= !rst && acc && haddr[7:0] == OFS_DATA && !hwrite;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rd_acc; acc && !hwrite; endsequence
  sequence s_rd_wait; !hreadyout ##1 hreadyout; endsequence
  a_read_wait: assert property (s_rd_acc |=> s_rd_wait)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  a_stretch_hold: assert property ($fell(scl_oe) |-> $past(dp_q) || $past(dp_q, 2))
    else $error("stretch ended without data access");
  a_stretch_release: assert property (rd_q && scl_oe |=> !scl_oe)
    else $error("stretch kept after data read");
  a_stretch_low: assert property ($rose(scl_oe) |-> !scl_i && !$past(scl_i))
    else $error("stretch began with clock high");
  a_ack_setup: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data pulled while clock high");
  a_ack_release: assert property ($fell(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("data released while clock high");
  a_irq_stretch: assert property ($rose(irq) |-> ##[0:8] scl_oe)
    else $error("interrupt without stretch");
endmodule
bind ise_slave_engine ise_slave_engine_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq));

// ===== tb/ise_i2c_master.sv
// behavioural two-wire bus master, open-drain outputs
`timescale 1ns/100ps
module ise_i2c_master (
  output logic      scl_m,
  output logic      sda_m,
  input  wire logic scl,
  input  wire logic sda
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // the high half starts only once a stretch is over
  task automatic bit_x(input logic b, output logic r);
    #80 sda_m = b;
    #80 scl_m = 1'b1;
    wait (scl === 1'b1);
    #80 r = sda;
    #80 scl_m = 1'b0;
  endtask
  // odd offset keeps the link edges off the system clock edges
  task automatic start;
    #7 sda_m = 1'b1;
    #80 scl_m = 1'b1;
    wait (scl === 1'b1);
    #160 sda_m = 1'b0;
    #160 scl_m = 1'b0;
  endtask
  task automatic stop;
    #87 sda_m = 1'b0;
    #80 scl_m = 1'b1;
    wait (scl === 1'b1);
    #160 sda_m = 1'b1;
    #160;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    #7;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack);
  endtask
endmodule

// ===== tb/tb_ise_slave_engine.sv
// self-checking bench of the two-wire slave engine
`timescale 1ns/100ps
module tb_ise_slave_engine;
  import ise_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        scl_o;
  logic        sda_o;
  logic        scl_oe;
  logic        sda_oe;
  logic        irq;
  logic        scl_m;
  logic        sda_m;
  wire         scl = scl_m & ~scl_oe;
  wire         sda = sda_m & ~sda_oe;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [31:0] r;
  logic [7:0]  q;
  logic        a;
  ise_slave_engine DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  ise_i2c_master u_m (.scl_m(scl_m), .sda_m(sda_m), .scl(scl), .sda(sda));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      summarize;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic [7:0] ad, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // waits for done, checks masking, then clears done
  task automatic serve;
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge sys_clk);
    chk(irq, 1'b1);
    xf(OFS_MASK, 1'b1, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    xf(OFS_MASK, 1'b1, 32'h1);
    xf(OFS_STAT, 1'b0, 32'h0);
    chk(r[ST_DONE], 1'b1);
    chk(scl_oe, 1'b1);
    xf(OFS_STAT, 1'b1, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
  endtask
  task automatic rx_one(input logic [7:0] d, input logic ack_exp);
    fork
      u_m.xfer(d, 1'b1, q, a);
      begin
        serve;
        xf(OFS_DATA, 1'b0, 32'h0);
        chk(r, {24'h0, d});
        chk(scl_oe, 1'b0);
      end
    join
    @(posedge sys_clk);
    chk(a, ack_exp);
  endtask
  task automatic t_regs;
    xf(OFS_CTRL, 1'b0, 32'h0);
    chk(r, 32'h0);
    chk({29'h0, hresp, scl_o, sda_o}, 32'h0);
    xf(OFS_MASK, 1'b0, 32'h0);
    chk(r, 32'h1);
    xf(8'h20, 1'b0, 32'h0);
    chk(r, 32'h0);
    xf(OFS_ADDR_MODE, 1'b1, 32'h54);
    xf(OFS_ADDR_MODE, 1'b0, 32'h0);
    chk(r, 32'h54);
    xf(OFS_CTRL, 1'b1, 32'h21);
    xf(OFS_ADDR_MODE, 1'b1, 32'h18);
    xf(OFS_ADDR_MODE, 1'b0, 32'h0);
    chk(r, 32'h18);
    xf(OFS_DIV, 1'b0, 32'h0);
    chk(r, {20'h0, DIV_BASE} << 4);
    xf(OFS_CTRL, 1'b1, 32'h3);
    $display("test regs done");
  endtask
  task automatic t_rx;
    u_m.start();
    @(posedge sys_clk);
    xf(OFS_CTRL, 1'b0, 32'h0);
    chk(r, 32'h83);
    rx_one(8'h54, 1'b0);
    rx_one(8'hA5, 1'b0);
    xf(OFS_CTRL, 1'b1, 32'h13);
    rx_one(8'h3C, 1'b1);
    xf(OFS_CTRL, 1'b1, 32'h3);
    $display("test rx done");
  endtask
  task automatic t_miss;
    u_m.start();
    u_m.xfer(8'h56, 1'b1, q, a);
    chk(a, 1'b1);
    chk(irq, 1'b0);
    u_m.stop();
    @(posedge sys_clk);
    xf(OFS_CTRL, 1'b0, 32'h0);
    chk(r, 32'h3);
    $display("test miss done");
  endtask
  task automatic t_tx;
    u_m.start();
    fork
      u_m.xfer(8'h55, 1'b1, q, a);
      begin
        serve;
        xf(OFS_CTRL, 1'b0, 32'h0);
        chk(r, 32'h8B);
        xf(OFS_DATA, 1'b1, 32'h3C);
      end
    join
    fork
      u_m.xfer(8'hFF, 1'b0, q, a);
      begin
        serve;
        xf(OFS_DATA, 1'b1, 32'hFF);
      end
    join
    chk(q, 8'h3C);
    u_m.stop();
    $display("test tx done");
  endtask
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_rx;
    t_miss;
    t_tx;
    @(posedge sys_clk);
    summarize;
  end
endmodule
